// file: hdl/eisu_pkg.sv
// Package of constants and types for the event interrupt and status unit.
//
// Notes on behaviour
// - Status bits 7..6 show baud watchdog state.
// - Status bits 5..4 show slave protocol state.
// - Status bit 2 set while diagnosis unfetched.
// - Status bit 0: 0 offline, 1 idle.
// - Status bits 15..12 hold silicon revision.
// - Baud code bits 11..8, 1111 while searching.
// - Requests latch regardless of mask; OR drives output.
// - Software writes may set request bits.
// - Writing 1 to acknowledge clears request bit, except bits 11, 10 and 6.
// - Event and acknowledge together keep bit set.
// - End of service drives output inactive.
// - Output stays quiet 1 us or 1 ms.
// - Polarity bit steers output; reset low active.
// - Bits 7..5: subscriber data, ext params, timeout.
// - Bits 4..1: timer, watchdog, baud, exchange.
// - Bit 0: offline entry or clock sync.
// - Bits 15..12: acyclic, response, cyclic, diagnosis.
// - Bits 11..8: prm, cfg, address, global control.
// - Mask 1 disables; all set after reset.
// - Prm and cfg bits cleared only by machines.
// - End of service bit clears itself.
package eisu_pkg;

    // ************************************************************
    // Register indices; byte address is four times the index.
    // ************************************************************
    localparam logic [3:0] IDX_REQ_L      = 4'h0;
    localparam logic [3:0] IDX_REQ_H      = 4'h1;
    localparam logic [3:0] IDX_PEND_ACK_L = 4'h2;
    localparam logic [3:0] IDX_PEND_ACK_H = 4'h3;
    localparam logic [3:0] IDX_STAT_MSK_L = 4'h4;
    localparam logic [3:0] IDX_STAT_MSK_H = 4'h5;
    localparam logic [3:0] IDX_CONTROL    = 4'h8;
    localparam logic [3:0] IDX_MASK_RD_L  = 4'h9;
    localparam logic [3:0] IDX_MASK_RD_H  = 4'hA;
    localparam logic [3:0] IDX_GC_CELL    = 4'hB;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int          CTL_POLARITY_BIT = 0;
    localparam int          CTL_EOS_BIT      = 1;
    localparam int          CTL_DELAY_BIT    = 2;
    localparam logic [15:0] REQ_RESET        = 16'h0000;
    localparam logic [15:0] MASK_RESET       = 16'hFFFF;
    localparam logic [15:0] ACK_PROTECTED    = 16'h0C40;
    localparam logic [15:0] PRM_CLEAR_BITS   = 16'h0840;
    localparam logic [15:0] CFG_CLEAR_BITS   = 16'h0400;
    localparam int          GC_EVENT_BIT     = 8;
    localparam logic [1:0]  WD_SEARCHING     = 2'b00;
    localparam logic [3:0]  BAUD_UNKNOWN     = 4'hF;

    // ************************************************************
    // Re-arm timing.
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS     = 25;
    localparam int unsigned REARM_SHORT_NS    = 1000;
    localparam int unsigned REARM_LONG_US     = 1000;
    localparam int unsigned REARM_SHORT_CYCLES = (REARM_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REARM_LONG_CYCLES  = (REARM_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          REARM_CNT_W        = 16;

    typedef enum logic {EISU_ARMED, EISU_HOLD} eisu_rearm_state_t;

endpackage

// file: hdl/eisu_rearm_timer.sv
// Quiet-time timer that holds the interrupt off after end of service.
`timescale 1ns/1ps
module eisu_rearm_timer #(
    parameter int unsigned SHORT_CYCLES = eisu_pkg::REARM_SHORT_CYCLES,
    parameter int unsigned LONG_CYCLES  = eisu_pkg::REARM_LONG_CYCLES
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Control
    input  wire logic start,
    input  wire logic long_sel,
    // Status
    output logic      hold
);

    eisu_pkg::eisu_rearm_state_t       state;
    eisu_pkg::eisu_rearm_state_t       next_state;
    logic [eisu_pkg::REARM_CNT_W-1:0]  count;
    logic [eisu_pkg::REARM_CNT_W-1:0]  next_count;

    // ************************************************************
    // Count down the quiet time; a new start restarts it.
    // ************************************************************
    always_comb begin
        next_state = state;
        next_count = count;
        if (start) begin
            next_state = eisu_pkg::EISU_HOLD;
            next_count = long_sel ? eisu_pkg::REARM_CNT_W'(LONG_CYCLES - 1)
                                  : eisu_pkg::REARM_CNT_W'(SHORT_CYCLES - 1);
        end else begin
            unique case (state)
                eisu_pkg::EISU_ARMED: begin
                    next_count = '0;
                end
                eisu_pkg::EISU_HOLD: begin
                    if (count == '0) begin
                        next_state = eisu_pkg::EISU_ARMED;
                    end else begin
                        next_count = count - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= eisu_pkg::EISU_ARMED;
            count <= '0;
            hold  <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            hold  <= (next_state == eisu_pkg::EISU_HOLD);
        end
    end

endmodule

// file: hdl/eisu_event_status.sv
// Event interrupt controller and device status word behind an AHB-Lite slave.
`timescale 1ns/1ps
module eisu_event_status #(
    parameter int unsigned LONG_REARM_CYCLES = eisu_pkg::REARM_LONG_CYCLES,
    // Value is arbitrary.
    parameter logic [3:0]  SILICON_REVISION  = 4'h3,
    parameter int          ADDR_W            = 8
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Event sources
    input  wire logic [15:0]       event_in,
    input  wire logic              prm_ack_clear,
    input  wire logic              cfg_ack_clear,
    input  wire logic [7:0]        global_control_cmd,
    // Device state
    input  wire logic [1:0]        baud_watchdog_state,
    input  wire logic [1:0]        slave_protocol_state,
    input  wire logic              diag_unfetched,
    input  wire logic              passive_idle,
    input  wire logic [3:0]        baud_code,
    // Interrupt pin
    output logic                   irq_pin
);

    // ************************************************************
    // State.
    // ************************************************************
    logic [15:0] event_request_reg;
    logic [15:0] event_mask_reg;
    logic        polarity;
    logic        rearm_delay_select;
    logic [7:0]  global_control_cell;
    logic        wr_pend;
    logic [3:0]  wr_idx;
    logic        irq_active;
    logic [15:0] next_request;
    logic [15:0] next_mask;
    logic        next_polarity;
    logic        next_delay_select;
    logic [7:0]  next_gc_cell;
    logic        next_wr_pend;
    logic [3:0]  next_wr_idx;
    logic        next_irq_active;
    logic        next_irq_pin;
    logic [31:0] next_hrdata;
    logic [15:0] pending_enabled_reg;
    logic [15:0] event_acknowledge_reg;
    logic [15:0] sw_set;
    logic [15:0] fsm_clear;
    logic [15:0] status_word;
    logic        end_of_service;
    logic        hold;
    logic        addr_ok;
    logic        rd_take;
    logic        wr_take;

    // ************************************************************
    // Helpers.
    // ************************************************************
    function automatic logic [15:0] place_byte(input logic high, input logic [7:0] b);
        place_byte = high ? {b, 8'h00} : {8'h00, b};
    endfunction

    function automatic logic wr_hit(input logic pend, input logic [3:0] idx, input logic [3:0] target);
        wr_hit = pend && (idx == target);
    endfunction

    // ************************************************************
    // Bus decode.
    // ************************************************************
    // Registers are one aligned word each; anything else reads zero.
    always_comb begin
        addr_ok = (haddr[1:0] == 2'b00);
        if (ADDR_W > 6) begin
            addr_ok = addr_ok && ((haddr >> 6) == '0);
        end
        rd_take = hsel && hready && htrans[1] && !hwrite;
        wr_take = hsel && hready && htrans[1] && hwrite && addr_ok;
    end

    // ************************************************************
    // Status word.
    // ************************************************************
    always_comb begin
        status_word[15:12] = SILICON_REVISION;
        status_word[11:8]  = (baud_watchdog_state == eisu_pkg::WD_SEARCHING) ?
                             eisu_pkg::BAUD_UNKNOWN : baud_code;
        status_word[7:6]   = baud_watchdog_state;
        status_word[5:4]   = slave_protocol_state;
        status_word[3]     = 1'b0;
        status_word[2]     = diag_unfetched;
        status_word[1]     = 1'b0;
        status_word[0]     = passive_idle;
    end

    // ************************************************************
    // Write effects of the data phase.
    // ************************************************************
    always_comb begin
        event_acknowledge_reg = '0;
        sw_set                = '0;
        if (wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_PEND_ACK_L) ||
            wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_PEND_ACK_H)) begin
            event_acknowledge_reg = place_byte(wr_idx[0], hwdata[7:0]);
        end
        if (wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_REQ_L) ||
            wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_REQ_H)) begin
            sw_set = place_byte(wr_idx[0], hwdata[7:0]);
        end
        fsm_clear = (prm_ack_clear ? eisu_pkg::PRM_CLEAR_BITS : 16'h0000) |
                    (cfg_ack_clear ? eisu_pkg::CFG_CLEAR_BITS : 16'h0000);
        end_of_service = wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_CONTROL) &&
                         hwdata[eisu_pkg::CTL_EOS_BIT];
    end

    // ************************************************************
    // Interrupt controller.
    // ************************************************************
    assign pending_enabled_reg = event_request_reg & ~event_mask_reg;

    always_comb begin
        // Sets are ORed in last, so a new event survives an acknowledge.
        next_request = (event_request_reg &
                        ~((event_acknowledge_reg & ~eisu_pkg::ACK_PROTECTED) | fsm_clear)) |
                       sw_set | event_in;
        next_mask         = event_mask_reg;
        next_polarity     = polarity;
        next_delay_select = rearm_delay_select;
        next_gc_cell      = global_control_cell;
        if (event_in[eisu_pkg::GC_EVENT_BIT]) begin
            next_gc_cell = global_control_cmd;
        end
        if (wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_STAT_MSK_L)) begin
            next_mask[7:0] = hwdata[7:0];
        end
        if (wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_STAT_MSK_H)) begin
            next_mask[15:8] = hwdata[7:0];
        end
        if (wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_CONTROL)) begin
            next_polarity     = hwdata[eisu_pkg::CTL_POLARITY_BIT];
            next_delay_select = hwdata[eisu_pkg::CTL_DELAY_BIT];
        end
        // One OR network, no priority and no vector.
        next_irq_active = (|pending_enabled_reg) && !hold && !end_of_service;
        next_irq_pin    = next_polarity ? next_irq_active : !next_irq_active;
    end

    eisu_rearm_timer #(
        .SHORT_CYCLES (eisu_pkg::REARM_SHORT_CYCLES),
        .LONG_CYCLES  (LONG_REARM_CYCLES)
    ) u_rearm (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .start    (end_of_service),
        .long_sel (rearm_delay_select),
        .hold     (hold)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_request_reg   <= eisu_pkg::REQ_RESET;
            event_mask_reg      <= eisu_pkg::MASK_RESET;
            polarity            <= 1'b0;
            rearm_delay_select  <= 1'b0;
            global_control_cell <= 8'h00;
            irq_active          <= 1'b0;
            irq_pin             <= 1'b1;
        end else begin
            event_request_reg   <= next_request;
            event_mask_reg      <= next_mask;
            polarity            <= next_polarity;
            rearm_delay_select  <= next_delay_select;
            global_control_cell <= next_gc_cell;
            irq_active          <= next_irq_active;
            irq_pin             <= next_irq_pin;
        end
    end

    // ************************************************************
    // Bus slave: zero wait states, always OKAY.
    // ************************************************************
    // Read data is sampled at the address phase, so a read right behind a
    // write sees the value from before that write.
    always_comb begin
        next_wr_pend = wr_take;
        next_wr_idx  = wr_take ? haddr[5:2] : 4'h0;
        next_hrdata  = 32'h0000_0000;
        if (rd_take && addr_ok) begin
            unique case (haddr[5:2])
                eisu_pkg::IDX_REQ_L:      next_hrdata[7:0] = event_request_reg[7:0];
                eisu_pkg::IDX_REQ_H:      next_hrdata[7:0] = event_request_reg[15:8];
                eisu_pkg::IDX_PEND_ACK_L: next_hrdata[7:0] = pending_enabled_reg[7:0];
                eisu_pkg::IDX_PEND_ACK_H: next_hrdata[7:0] = pending_enabled_reg[15:8];
                eisu_pkg::IDX_STAT_MSK_L: next_hrdata[7:0] = status_word[7:0];
                eisu_pkg::IDX_STAT_MSK_H: next_hrdata[7:0] = status_word[15:8];
                eisu_pkg::IDX_CONTROL: begin
                    next_hrdata[eisu_pkg::CTL_POLARITY_BIT] = polarity;
                    next_hrdata[eisu_pkg::CTL_DELAY_BIT]    = rearm_delay_select;
                end
                eisu_pkg::IDX_MASK_RD_L:  next_hrdata[7:0] = event_mask_reg[7:0];
                eisu_pkg::IDX_MASK_RD_H:  next_hrdata[7:0] = event_mask_reg[15:8];
                eisu_pkg::IDX_GC_CELL:    next_hrdata[7:0] = global_control_cell;
                default:                  next_hrdata      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_idx    <= 4'h0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= next_wr_pend;
            wr_idx    <= next_wr_idx;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    event_latch_a: assert property ((event_in != 16'h0000) |=>
        ((event_request_reg & $past(event_in)) == $past(event_in)))
        else $error("Arriving event was not latched.");

    ack_clear_a: assert property ((event_acknowledge_reg[0] && !event_in[0] && !sw_set[0]) |=>
        !event_request_reg[0])
        else $error("Acknowledge did not clear request bit 0.");

    ack_protect_a: assert property (event_request_reg[11] && event_acknowledge_reg[11] &&
        !prm_ack_clear |=> event_request_reg[11])
        else $error("Parameter request cleared by acknowledge.");

    mask_gate_a: assert property ((pending_enabled_reg == 16'h0000) |=> !irq_active)
        else $error("Interrupt active with nothing pending.");

    raise_irq_a: assert property (((|pending_enabled_reg) && !hold && !end_of_service) |=>
        irq_active)
        else $error("Unmasked pending event did not raise interrupt.");

    eos_quiet_a: assert property ((end_of_service && !rearm_delay_select) |=>
        !irq_active [*8])
        else $error("Interrupt reasserted inside quiet time.");

    eos_drop_a: assert property (end_of_service |=> !irq_active)
        else $error("End of service did not drop the interrupt.");

    low_active_a: assert property ((!polarity && irq_active) |-> !irq_pin)
        else $error("Low active interrupt pin not low.");

    baud_search_a: assert property ((baud_watchdog_state == eisu_pkg::WD_SEARCHING) |->
        (status_word[11:8] == eisu_pkg::BAUD_UNKNOWN))
        else $error("Baud field not all ones while searching.");

    sw_set_a: assert property ((sw_set != 16'h0000) |=>
        ((event_request_reg & $past(sw_set)) == $past(sw_set)))
        else $error("Software set lost.");

    prm_clear_a: assert property ((prm_ack_clear && !event_in[11] && !sw_set[11]) |=>
        !event_request_reg[11])
        else $error("Parameter request not cleared.");

    cfg_protect_a: assert property (event_request_reg[10] && event_acknowledge_reg[10] &&
        !cfg_ack_clear |=> event_request_reg[10])
        else $error("Config request cleared by acknowledge.");

    ack_keep_a: assert property ((event_acknowledge_reg[3] && event_in[3]) |=>
        event_request_reg[3])
        else $error("Event lost to acknowledge.");

    mask_keep_a: assert property (!wr_pend |=> $stable(event_mask_reg))
        else $error("Mask changed without a write.");

    mask_write_a: assert property (wr_hit(wr_pend, wr_idx, eisu_pkg::IDX_STAT_MSK_L) |=>
        (event_mask_reg[7:0] == $past(hwdata[7:0])))
        else $error("Low mask byte not written.");

    pend_read_a: assert property (rd_take && addr_ok &&
        (haddr[5:2] == eisu_pkg::IDX_PEND_ACK_L) |=>
        (hrdata[7:0] == $past(pending_enabled_reg[7:0])))
        else $error("Pending read wrong.");

    stat_state_a: assert property (rd_take && addr_ok &&
        (haddr[5:2] == eisu_pkg::IDX_STAT_MSK_L) |=>
        (hrdata[7:4] == $past({baud_watchdog_state, slave_protocol_state})))
        else $error("State fields read wrong.");

    stat_flags_a: assert property (rd_take && addr_ok &&
        (haddr[5:2] == eisu_pkg::IDX_STAT_MSK_L) |=>
        (hrdata[3:0] == {1'b0, $past(diag_unfetched), 1'b0, $past(passive_idle)}))
        else $error("Status flags read wrong.");

    rev_field_a: assert property (rd_take && addr_ok &&
        (haddr[5:2] == eisu_pkg::IDX_STAT_MSK_H) |=>
        (hrdata[7:4] == SILICON_REVISION))
        else $error("Revision read wrong.");

    eos_read_a: assert property (rd_take && addr_ok &&
        (haddr[5:2] == eisu_pkg::IDX_CONTROL) |=> !hrdata[eisu_pkg::CTL_EOS_BIT])
        else $error("End of service bit not 0.");

    gc_capture_a: assert property (event_in[eisu_pkg::GC_EVENT_BIT] |=>
        (global_control_cell == $past(global_control_cmd)))
        else $error("Command not captured.");

    gc_keep_a: assert property (!event_in[eisu_pkg::GC_EVENT_BIT] |=> $stable(global_control_cell))
        else $error("Command cell changed.");

    eos_hold_a: assert property (end_of_service |=> hold)
        else $error("Quiet time did not start.");

    hold_quiet_a: assert property (hold |=> !irq_active)
        else $error("Interrupt in quiet time.");

    high_active_a: assert property ((polarity && irq_active) |-> irq_pin)
        else $error("High active pin not high.");

    idle_level_a: assert property (!irq_active |-> (irq_pin != polarity))
        else $error("Idle pin at active level.");

endmodule

// file: dv/eisu_host_irq_model.sv
// Host interrupt input model that counts the active edges seen on the interrupt pin.
`timescale 1ns/1ps
module eisu_host_irq_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Interrupt input
    input  wire logic irq_pin,
    input  wire logic active_high,
    // Observation
    output int        edges
);
    logic last_active;

    // ************************************************************
    // Edge detection.
    // ************************************************************
    // An edge-triggered host re-enters only on a fresh inactive-to-active edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_active <= 1'b0;
            edges       <= 0;
        end else begin
            last_active <= (irq_pin === active_high);
            if ((irq_pin === active_high) && !last_active) begin
                edges <= edges + 1;
            end
        end
    end
endmodule

// file: dv/tb_top.sv
// Self-checking testbench for the event interrupt and status unit.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    $display("[ERR] %s expected %0h seen %0h", what, exp, got); bad_count++; end end
module tb_top;
    localparam int         LONG_N = 100;
    // Value is arbitrary.
    localparam logic [3:0] REV    = 4'h5;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        hready;
    logic [15:0] event_in = 16'h0000;
    logic        prm_ack_clear = 1'b0;
    logic        cfg_ack_clear = 1'b0;
    logic [7:0]  gc_cmd = 8'h00;
    logic [1:0]  wd_st = 2'b00;
    logic [1:0]  sp_st = 2'b00;
    logic        diag = 1'b0;
    logic        idle = 1'b0;
    logic [3:0]  baud = 4'h0;
    logic        irq_pin;
    logic        pol = 1'b0;
    logic [7:0]  rd;
    int          edges;
    int          n;
    int          bad_count = 0;
    int          n_compared = 0;

    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;

    eisu_event_status #(.LONG_REARM_CYCLES(LONG_N), .SILICON_REVISION(REV), .ADDR_W(8)) i_eisu_event_status (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .event_in(event_in), .prm_ack_clear(prm_ack_clear), .cfg_ack_clear(cfg_ack_clear),
        .global_control_cmd(gc_cmd), .baud_watchdog_state(wd_st), .slave_protocol_state(sp_st),
        .diag_unfetched(diag), .passive_idle(idle), .baud_code(baud), .irq_pin(irq_pin));

    eisu_host_irq_model i_eisu_host_irq_model (
        .hclk(hclk), .hresetn(hresetn), .irq_pin(irq_pin), .active_high(pol), .edges(edges));

    // ************************************************************
    // Bus and stimulus tasks.
    // ************************************************************
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_hi();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad_count++;
            conclude();
        end
    endtask

    // One whole transfer; ev is raised during the data phase so it meets a write there.
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] wd, input logic [15:0] ev);
        hsel   <= 1'b1;
        haddr  <= {2'b00, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        wait_hi();
        hsel     <= 1'b0;
        htrans   <= 2'b00;
        hwdata   <= {24'h00_0000, wd};
        event_in <= ev;
        wait_hi();
        rd = hrdata[7:0];
        event_in <= 16'h0000;
    endtask

    task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 16'h0000);
        `CHK("read data", exp, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic pulse(input logic [15:0] v, input logic pa, input logic pc);
        @(posedge hclk);
        event_in      <= v;
        prm_ack_clear <= pa;
        cfg_ack_clear <= pc;
        @(posedge hclk);
        event_in      <= 16'h0000;
        prm_ack_clear <= 1'b0;
        cfg_ack_clear <= 1'b0;
    endtask

    // Cycles until the active-low pin is seen asserted again.
    task automatic quiet(output int cnt);
        cnt = 0;
        do begin
            @(posedge hclk);
            cnt++;
        end while (irq_pin !== 1'b0 && cnt < 300);
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK("irq after reset", 1'b1, irq_pin)
        rchk(eisu_pkg::IDX_REQ_L, 8'h00);
        rchk(eisu_pkg::IDX_REQ_H, 8'h00);
        rchk(eisu_pkg::IDX_MASK_RD_L, 8'hFF);
        rchk(eisu_pkg::IDX_MASK_RD_H, 8'hFF);
        rchk(4'h6, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wd_st <= 2'(i);
            sp_st <= 2'(i);
            diag  <= i[0];
            idle  <= i[1];
            baud  <= (i == 1) ? 4'h0 : 4'h9;
            rchk(eisu_pkg::IDX_STAT_MSK_L, {2'(i), 2'(i), 1'b0, i[0], 1'b0, i[1]});
            rchk(eisu_pkg::IDX_STAT_MSK_H, {REV, (i == 0) ? 4'hF : ((i == 1) ? 4'h0 : 4'h9)});
        end
        $display("test status done");
        gc_cmd <= 8'hA5;
        pulse(16'hFFFF, 1'b0, 1'b0);
        rchk(eisu_pkg::IDX_REQ_L, 8'hFF);
        rchk(eisu_pkg::IDX_REQ_H, 8'hFF);
        rchk(eisu_pkg::IDX_GC_CELL, 8'hA5);
        `CHK("irq masked", 1'b1, irq_pin)
        bus(1'b1, eisu_pkg::IDX_PEND_ACK_L, 8'hFF, 16'h0000);
        bus(1'b1, eisu_pkg::IDX_PEND_ACK_H, 8'hFF, 16'h0000);
        rchk(eisu_pkg::IDX_REQ_L, 8'h40);
        rchk(eisu_pkg::IDX_REQ_H, 8'h0C);
        pulse(16'h0000, 1'b1, 1'b0);
        rchk(eisu_pkg::IDX_REQ_L, 8'h00);
        rchk(eisu_pkg::IDX_REQ_H, 8'h04);
        pulse(16'h0000, 1'b0, 1'b1);
        rchk(eisu_pkg::IDX_REQ_H, 8'h00);
        bus(1'b1, eisu_pkg::IDX_REQ_H, 8'h30, 16'h0000);
        rchk(eisu_pkg::IDX_REQ_H, 8'h30);
        bus(1'b1, eisu_pkg::IDX_PEND_ACK_H, 8'h30, 16'h0000);
        bus(1'b1, eisu_pkg::IDX_REQ_L, 8'h08, 16'h0000);
        bus(1'b1, eisu_pkg::IDX_PEND_ACK_L, 8'h08, 16'h0008);
        rchk(eisu_pkg::IDX_REQ_L, 8'h08);
        bus(1'b1, eisu_pkg::IDX_PEND_ACK_L, 8'h08, 16'h0000);
        rchk(eisu_pkg::IDX_REQ_L, 8'h00);
        rchk(eisu_pkg::IDX_REQ_H, 8'h00);
        $display("test requests done");
        // Stale request cleared before unmasking, so only the fresh event counts.
        bus(1'b1, eisu_pkg::IDX_STAT_MSK_L, 8'hFB, 16'h0000);
        rchk(eisu_pkg::IDX_MASK_RD_L, 8'hFB);
        pulse(16'h0004, 1'b0, 1'b0);
        repeat (3) @(posedge hclk);
        `CHK("irq asserted low", 1'b0, irq_pin)
        rchk(eisu_pkg::IDX_PEND_ACK_L, 8'h04);
        bus(1'b1, eisu_pkg::IDX_CONTROL, 8'h02, 16'h0000);
        #1 `CHK("irq after end of service", 1'b1, irq_pin)
        quiet(n);
        `CHK("short quiet", 1'b1, (n >= 40 && n <= 45))
        rchk(eisu_pkg::IDX_CONTROL, 8'h00);
        bus(1'b1, eisu_pkg::IDX_CONTROL, 8'h04, 16'h0000);
        bus(1'b1, eisu_pkg::IDX_CONTROL, 8'h06, 16'h0000);
        quiet(n);
        `CHK("long quiet", 1'b1, (n >= LONG_N && n <= LONG_N + 6))
        @(posedge hclk);
        `CHK("host edges", 3, edges)
        pol <= 1'b1;
        bus(1'b1, eisu_pkg::IDX_CONTROL, 8'h05, 16'h0000);
        repeat (3) @(posedge hclk);
        `CHK("irq active high", 1'b1, irq_pin)
        bus(1'b1, eisu_pkg::IDX_PEND_ACK_L, 8'h04, 16'h0000);
        repeat (3) @(posedge hclk);
        `CHK("irq after ack", 1'b0, irq_pin)
        $display("test interrupt done");
        conclude();
    end
endmodule
